/* File: core/uss_pkg.sv */
/*
  constants for the synchronous slave serial unit: register offsets,
  field positions, reset values and word sizes.
  assumes a plain 3-bit register port with 8-bit data.
*/
package uss_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int WORD_W = 9;

  localparam logic [ADDR_W-1:0] ADDR_TX_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RX_CTRL = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_TX_DATA = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_RX_DATA = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 3'h4;

  // transmit_status_control
  localparam int TXC_TX_ENABLE = 0;
  localparam int TXC_NINTH_ENABLE = 1;
  localparam int TXC_NINTH_VALUE = 2;
  localparam int TXC_CLOCKED_MODE = 3;
  localparam int TXC_MASTER_SEL = 4;
  localparam int TXC_BUF_EMPTY = 5;
  localparam int TXC_SHIFT_BUSY = 6;

  // receive_status_control
  localparam int RXC_PORT_ENABLE = 0;
  localparam int RXC_SINGLE_RX = 1;
  localparam int RXC_CONT_RX = 2;
  localparam int RXC_NINTH_ENABLE = 3;
  localparam int RXC_NINTH_VALUE = 4;
  localparam int RXC_OVERRUN = 5;
  localparam int RXC_FULL = 6;

  // interrupt enables
  localparam int IRQ_PERIPH = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_RX = 2;
  localparam int IRQ_GLOBAL = 3;

  localparam logic [DATA_W-1:0] TX_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] RX_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_EN_RST = 8'h00;

  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;
  localparam int RX_DEPTH = 2;
  localparam int SYNC_STAGES = 3;
endpackage

/* File: core/uss_core.sv */
/*
  synchronous slave serial unit: register port, transmit buffer and
  shifter, two-word receive queue, overrun handling, wake and irq requests.
  assumes the external master supplies serial_timing_clk only while
  shifting, and that the data pin is sampled by the master on falling edges.
*/

module uss_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] agree;

  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      dout <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a change counts once stages two and three agree
      dout <= (s3_reg & agree) | (dout & ~agree);
    end
  end
endmodule

module uss_core #(
  parameter int RX_DEPTH = uss_pkg::RX_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [uss_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [uss_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [uss_pkg::DATA_W-1:0] reg_rdata,
  input wire logic serial_timing_clk,
  input wire logic serial_line_in,
  output logic serial_line_out,
  output logic serial_line_oe,
  output logic wake_req,
  output logic irq_req
);
  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CNT_W = $clog2(RX_DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(RX_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RX_DEPTH);

  // control fields
  logic tx_enable_reg;
  logic tx_ninth_bit_enable_reg;
  logic tx_ninth_bit_value_reg;
  logic clocked_mode_select_reg;
  logic clock_source_master_sel_reg;
  logic serial_port_enable_reg;
  logic single_receive_enable_reg;
  logic continuous_receive_enable_reg;
  logic rx_ninth_bit_enable_reg;
  logic peripheral_irq_enable_reg;
  logic tx_irq_enable_reg;
  logic rx_irq_enable_reg;
  logic global_irq_enable_reg;

  // transmit side, reference domain
  logic [uss_pkg::WORD_W-1:0] tx_data_buffer_reg;
  logic tx_buf_full_reg;
  logic [uss_pkg::WORD_W-1:0] tx_hold_reg;
  logic tx_pending_reg;
  logic tx_req_tgl_reg;
  logic tx_done_seen_reg;

  // receive side, reference domain
  logic [uss_pkg::WORD_W-1:0] rx_queue_reg [RX_DEPTH];
  logic [PTR_W-1:0] rx_wr_ptr_reg;
  logic [PTR_W-1:0] rx_rd_ptr_reg;
  logic [CNT_W-1:0] rx_count_reg;
  logic overrun_reg;
  logic rx_seen_reg;
  logic [uss_pkg::DATA_W-1:0] rdata_reg;

  // link domain
  logic link_rst;
  logic [uss_pkg::WORD_W-1:0] tx_shift_reg;
  logic [3:0] tx_cnt_reg;
  logic [3:0] tx_len_reg;
  logic tx_busy_reg;
  logic tx_done_tgl_reg;
  logic line_out_reg;
  logic [uss_pkg::WORD_W-1:0] rx_shift_reg;
  logic [3:0] rx_cnt_reg;
  logic [uss_pkg::WORD_W-1:0] rx_hold_reg;
  logic rx_tgl_reg;

  // crossings
  logic [4:0] cfg_to_link;
  logic [4:0] cfg_link;
  logic [1:0] evt_to_ref;
  logic [1:0] evt_ref;

  logic unit_on;
  logic tx_mode;
  logic rx_mode;
  logic wr_tx_ctrl;
  logic wr_rx_ctrl;
  logic wr_irq_en;
  logic wr_tx_data;
  logic rd_rx_data;
  logic rx_empty;
  logic tx_done_evt;
  logic rx_evt;
  logic rx_push;
  logic rx_pop;
  logic tx_buffer_empty_flag;
  logic rx_full_flag;
  logic [uss_pkg::WORD_W-1:0] rx_head;
  logic [uss_pkg::WORD_W-1:0] rx_word;
  logic [3:0] rx_len;
  logic link_tx_mode;
  logic link_rx_mode;
  logic link_tx9;
  logic link_rx9;
  logic link_req;

  assign unit_on = serial_port_enable_reg & clocked_mode_select_reg & ~clock_source_master_sel_reg;
  assign tx_mode = unit_on & tx_enable_reg & ~single_receive_enable_reg & ~continuous_receive_enable_reg;
  assign rx_mode = unit_on & continuous_receive_enable_reg;

  assign wr_tx_ctrl = reg_wr & (reg_addr == uss_pkg::ADDR_TX_CTRL);
  assign wr_rx_ctrl = reg_wr & (reg_addr == uss_pkg::ADDR_RX_CTRL);
  assign wr_irq_en = reg_wr & (reg_addr == uss_pkg::ADDR_IRQ_EN);
  assign wr_tx_data = reg_wr & (reg_addr == uss_pkg::ADDR_TX_DATA);
  assign rd_rx_data = reg_rd & (reg_addr == uss_pkg::ADDR_RX_DATA);

  assign rx_empty = (rx_count_reg == '0);
  assign rx_full_flag = ~rx_empty;
  assign rx_head = rx_queue_reg[rx_rd_ptr_reg];
  assign tx_buffer_empty_flag = ~tx_buf_full_reg;

  assign tx_done_evt = evt_ref[1] ^ tx_done_seen_reg;
  assign rx_evt = evt_ref[0] ^ rx_seen_reg;
  // a pop in the same cycle frees the head slot for the new word
  assign rx_push = rx_evt & rx_mode & ~overrun_reg & ((rx_count_reg != CNT_FULL) | rx_pop);
  assign rx_pop = rd_rx_data & ~rx_empty;

  assign wake_req = (tx_buffer_empty_flag & peripheral_irq_enable_reg & tx_irq_enable_reg & tx_mode)
    | (rx_full_flag & rx_irq_enable_reg);
  assign irq_req = wake_req & global_irq_enable_reg;

  // configuration registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_enable_reg <= uss_pkg::TX_CTRL_RST[uss_pkg::TXC_TX_ENABLE];
      tx_ninth_bit_enable_reg <= uss_pkg::TX_CTRL_RST[uss_pkg::TXC_NINTH_ENABLE];
      tx_ninth_bit_value_reg <= uss_pkg::TX_CTRL_RST[uss_pkg::TXC_NINTH_VALUE];
      clocked_mode_select_reg <= uss_pkg::TX_CTRL_RST[uss_pkg::TXC_CLOCKED_MODE];
      clock_source_master_sel_reg <= uss_pkg::TX_CTRL_RST[uss_pkg::TXC_MASTER_SEL];
      serial_port_enable_reg <= uss_pkg::RX_CTRL_RST[uss_pkg::RXC_PORT_ENABLE];
      single_receive_enable_reg <= uss_pkg::RX_CTRL_RST[uss_pkg::RXC_SINGLE_RX];
      continuous_receive_enable_reg <= uss_pkg::RX_CTRL_RST[uss_pkg::RXC_CONT_RX];
      rx_ninth_bit_enable_reg <= uss_pkg::RX_CTRL_RST[uss_pkg::RXC_NINTH_ENABLE];
      peripheral_irq_enable_reg <= uss_pkg::IRQ_EN_RST[uss_pkg::IRQ_PERIPH];
      tx_irq_enable_reg <= uss_pkg::IRQ_EN_RST[uss_pkg::IRQ_TX];
      rx_irq_enable_reg <= uss_pkg::IRQ_EN_RST[uss_pkg::IRQ_RX];
      global_irq_enable_reg <= uss_pkg::IRQ_EN_RST[uss_pkg::IRQ_GLOBAL];
    end else begin
      if (wr_tx_ctrl) begin
        tx_enable_reg <= reg_wdata[uss_pkg::TXC_TX_ENABLE];
        tx_ninth_bit_enable_reg <= reg_wdata[uss_pkg::TXC_NINTH_ENABLE];
        tx_ninth_bit_value_reg <= reg_wdata[uss_pkg::TXC_NINTH_VALUE];
        clocked_mode_select_reg <= reg_wdata[uss_pkg::TXC_CLOCKED_MODE];
        clock_source_master_sel_reg <= reg_wdata[uss_pkg::TXC_MASTER_SEL];
      end
      if (wr_rx_ctrl) begin
        serial_port_enable_reg <= reg_wdata[uss_pkg::RXC_PORT_ENABLE];
        single_receive_enable_reg <= reg_wdata[uss_pkg::RXC_SINGLE_RX];
        continuous_receive_enable_reg <= reg_wdata[uss_pkg::RXC_CONT_RX];
        rx_ninth_bit_enable_reg <= reg_wdata[uss_pkg::RXC_NINTH_ENABLE];
      end
      if (wr_irq_en) begin
        peripheral_irq_enable_reg <= reg_wdata[uss_pkg::IRQ_PERIPH];
        tx_irq_enable_reg <= reg_wdata[uss_pkg::IRQ_TX];
        rx_irq_enable_reg <= reg_wdata[uss_pkg::IRQ_RX];
        global_irq_enable_reg <= reg_wdata[uss_pkg::IRQ_GLOBAL];
      end
    end
  end

  // transmit buffer and hand-off to the shifter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_data_buffer_reg <= '0;
      tx_buf_full_reg <= 1'b0;
      tx_hold_reg <= '0;
      tx_pending_reg <= 1'b0;
      tx_req_tgl_reg <= 1'b0;
    end else if (!serial_port_enable_reg) begin
      tx_buf_full_reg <= 1'b0;
      tx_pending_reg <= 1'b0;
      tx_req_tgl_reg <= 1'b0;
    end else begin
      if (wr_tx_data && !tx_buf_full_reg) begin
        // ninth bit is taken from the value set before the low byte
        tx_data_buffer_reg <= {tx_ninth_bit_enable_reg & tx_ninth_bit_value_reg, reg_wdata};
        tx_buf_full_reg <= 1'b1;
      end else if (tx_buf_full_reg && !tx_pending_reg && tx_mode) begin
        tx_hold_reg <= tx_data_buffer_reg;
        tx_buf_full_reg <= 1'b0;
        tx_req_tgl_reg <= ~tx_req_tgl_reg;
      end
      if (tx_buf_full_reg && !tx_pending_reg && tx_mode && !wr_tx_data) begin
        tx_pending_reg <= 1'b1;
      end else if (tx_done_evt) begin
        tx_pending_reg <= 1'b0;
      end
    end
  end

  // toggle trackers follow the synchronised value even while disabled
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_done_seen_reg <= 1'b0;
      rx_seen_reg <= 1'b0;
    end else begin
      tx_done_seen_reg <= evt_ref[1];
      rx_seen_reg <= evt_ref[0];
    end
  end

  // receive queue
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < RX_DEPTH; i++) begin
        rx_queue_reg[i] <= '0;
      end
      rx_wr_ptr_reg <= '0;
      rx_rd_ptr_reg <= '0;
      rx_count_reg <= '0;
    end else if (!serial_port_enable_reg) begin
      rx_wr_ptr_reg <= '0;
      rx_rd_ptr_reg <= '0;
      rx_count_reg <= '0;
    end else begin
      if (rx_push) begin
        rx_queue_reg[rx_wr_ptr_reg] <= rx_hold_reg;
        rx_wr_ptr_reg <= (rx_wr_ptr_reg == PTR_LAST) ? '0 : rx_wr_ptr_reg + 1'b1;
      end
      if (rx_pop) begin
        rx_rd_ptr_reg <= (rx_rd_ptr_reg == PTR_LAST) ? '0 : rx_rd_ptr_reg + 1'b1;
      end
      if (rx_push && !rx_pop) begin
        rx_count_reg <= rx_count_reg + 1'b1;
      end else if (rx_pop && !rx_push) begin
        rx_count_reg <= rx_count_reg - 1'b1;
      end
    end
  end

  // overrun: a completion into a full queue sets it; setting wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overrun_reg <= 1'b0;
    end else if (rx_evt && rx_mode && (rx_count_reg == CNT_FULL) && !rx_pop) begin
      overrun_reg <= 1'b1;
    end else if (!continuous_receive_enable_reg || !serial_port_enable_reg) begin
      overrun_reg <= 1'b0;
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        uss_pkg::ADDR_TX_CTRL: rdata_reg <= {1'b0, tx_pending_reg, tx_buffer_empty_flag,
          clock_source_master_sel_reg, clocked_mode_select_reg, tx_ninth_bit_value_reg,
          tx_ninth_bit_enable_reg, tx_enable_reg};
        uss_pkg::ADDR_RX_CTRL: rdata_reg <= {1'b0, rx_full_flag, overrun_reg,
          rx_head[uss_pkg::WORD_W-1] & ~rx_empty, rx_ninth_bit_enable_reg,
          continuous_receive_enable_reg, single_receive_enable_reg, serial_port_enable_reg};
        uss_pkg::ADDR_RX_DATA: rdata_reg <= rx_empty ? '0 : rx_head[uss_pkg::DATA_W-1:0];
        uss_pkg::ADDR_IRQ_EN: rdata_reg <= {4'h0, global_irq_enable_reg, rx_irq_enable_reg,
          tx_irq_enable_reg, peripheral_irq_enable_reg};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata = rdata_reg;

  // crossings between the two domains
  assign cfg_to_link = {tx_req_tgl_reg, tx_mode, rx_mode,
    tx_ninth_bit_enable_reg, rx_ninth_bit_enable_reg};
  assign evt_to_ref = {tx_done_tgl_reg, rx_tgl_reg};

  uss_sync #(.WIDTH(5)) u_sync_link (
    .clk(serial_timing_clk),
    .rst(link_rst),
    .din(cfg_to_link),
    .dout(cfg_link)
  );

  // cleared with the link so a toggle reset by port-off is not seen as an event
  uss_sync #(.WIDTH(2)) u_sync_ref (
    .clk(ref_clk),
    .rst(link_rst),
    .din(evt_to_ref),
    .dout(evt_ref)
  );

  assign link_req = cfg_link[4];
  assign link_tx_mode = cfg_link[3];
  assign link_rx_mode = cfg_link[2];
  assign link_tx9 = cfg_link[1];
  assign link_rx9 = cfg_link[0];

  // link logic is held in reset while the port is disabled
  assign link_rst = rst | ~serial_port_enable_reg;

  // transmit shifter, one bit per master clock edge, lsb first
  always_ff @(posedge serial_timing_clk or posedge link_rst) begin
    if (link_rst) begin
      tx_shift_reg <= '0;
      tx_cnt_reg <= '0;
      tx_len_reg <= uss_pkg::BITS_SHORT;
      tx_busy_reg <= 1'b0;
      tx_done_tgl_reg <= 1'b0;
      line_out_reg <= 1'b0;
    end else if (!tx_busy_reg) begin
      if (link_tx_mode && (link_req != tx_done_tgl_reg)) begin
        tx_shift_reg <= tx_hold_reg;
        line_out_reg <= tx_hold_reg[0];
        tx_cnt_reg <= 4'h1;
        tx_len_reg <= link_tx9 ? uss_pkg::BITS_LONG : uss_pkg::BITS_SHORT;
        tx_busy_reg <= 1'b1;
      end
    end else if (tx_cnt_reg == tx_len_reg) begin
      tx_busy_reg <= 1'b0;
      tx_done_tgl_reg <= ~tx_done_tgl_reg;
    end else begin
      line_out_reg <= tx_shift_reg[tx_cnt_reg];
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
    end
  end

  assign serial_line_out = line_out_reg;
  assign serial_line_oe = tx_busy_reg;

  // receive shifter
  assign rx_len = link_rx9 ? uss_pkg::BITS_LONG : uss_pkg::BITS_SHORT;

  always_comb begin
    rx_word = rx_shift_reg;
    rx_word[rx_cnt_reg] = serial_line_in;
    if (!link_rx9) begin
      rx_word[uss_pkg::WORD_W-1] = 1'b0;
    end
  end

  always_ff @(posedge serial_timing_clk or posedge link_rst) begin
    if (link_rst) begin
      rx_shift_reg <= '0;
      rx_cnt_reg <= '0;
      rx_hold_reg <= '0;
      rx_tgl_reg <= 1'b0;
    end else if (!link_rx_mode) begin
      rx_cnt_reg <= '0;
    end else if (rx_cnt_reg == rx_len - 4'h1) begin
      rx_hold_reg <= rx_word;
      rx_tgl_reg <= ~rx_tgl_reg;
      rx_cnt_reg <= '0;
    end else begin
      rx_shift_reg <= rx_word;
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
    end
  end
endmodule

/* File: verif/uss_core_sva.sv */
/*
  port-level properties of the synchronous slave serial unit.
  assumes it is bound to uss_core and sees only that module's ports.
*/
module uss_core_sva #(
  parameter int RX_DEPTH = uss_pkg::RX_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [uss_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [uss_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [uss_pkg::DATA_W-1:0] reg_rdata,
  input wire logic serial_timing_clk,
  input wire logic serial_line_oe,
  input wire logic wake_req,
  input wire logic irq_req
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] tx_sh;
  logic [3:0] rx_sh;
  logic [3:0] irq_sh;
  logic [1:0] off_q;
  wire logic rx_off = !(rx_sh[uss_pkg::RXC_CONT_RX] && rx_sh[uss_pkg::RXC_PORT_ENABLE]);

  // shadows of the writable control fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_sh <= uss_pkg::TX_CTRL_RST[4:0];
      rx_sh <= uss_pkg::RX_CTRL_RST[3:0];
      irq_sh <= uss_pkg::IRQ_EN_RST[3:0];
    end else if (reg_wr) begin
      if (reg_addr == uss_pkg::ADDR_TX_CTRL) tx_sh <= reg_wdata[4:0];
      if (reg_addr == uss_pkg::ADDR_RX_CTRL) rx_sh <= reg_wdata[3:0];
      if (reg_addr == uss_pkg::ADDR_IRQ_EN) irq_sh <= reg_wdata[3:0];
    end
  end

  // receive off and port off, one cycle ago
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      off_q <= 2'h3;
    end else begin
      off_q <= {!rx_sh[uss_pkg::RXC_PORT_ENABLE], rx_off};
    end
  end

  sequence s_word8;
    serial_line_oe [*8];
  endsequence

  property p_rdata_idle;
    @(posedge ref_clk) disable iff (rst) !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read slot");
  property p_unmapped;
    @(posedge ref_clk) disable iff (rst) reg_rd && reg_addr > uss_pkg::ADDR_IRQ_EN |=> reg_rdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_tx_rb;
    @(posedge ref_clk) disable iff (rst) reg_rd && reg_addr == uss_pkg::ADDR_TX_CTRL |=> reg_rdata[4:0] == tx_sh;
  endproperty
  a_tx_rb: assert property (p_tx_rb) else $error("transmit control readback wrong");
  property p_rx_rb;
    @(posedge ref_clk) disable iff (rst) reg_rd && reg_addr == uss_pkg::ADDR_RX_CTRL |=> reg_rdata[3:0] == rx_sh;
  endproperty
  a_rx_rb: assert property (p_rx_rb) else $error("receive control readback wrong");
  property p_wake;
    @(posedge ref_clk) disable iff (rst)
      wake_req |-> (irq_sh[uss_pkg::IRQ_PERIPH] && irq_sh[uss_pkg::IRQ_TX]) || irq_sh[uss_pkg::IRQ_RX];
  endproperty
  a_wake: assert property (p_wake) else $error("wake without its enables");
  property p_irq;
    @(posedge ref_clk) disable iff (rst) irq_req == (wake_req && irq_sh[uss_pkg::IRQ_GLOBAL]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request not wake and global");
  property p_ovr_clr;
    @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == uss_pkg::ADDR_RX_CTRL && rx_off && off_q[0] |=> !reg_rdata[uss_pkg::RXC_OVERRUN];
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun stands with receive off");
  property p_off_rx;
    @(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == uss_pkg::ADDR_RX_DATA && !rx_sh[uss_pkg::RXC_PORT_ENABLE] && off_q[1] |=> reg_rdata == '0;
  endproperty
  a_off_rx: assert property (p_off_rx) else $error("receive data kept with port off");
  property p_oe8;
    @(posedge serial_timing_clk) disable iff (rst)
      $rose(serial_line_oe) && !tx_sh[uss_pkg::TXC_NINTH_ENABLE] |-> s_word8 ##1 !serial_line_oe;
  endproperty
  a_oe8: assert property (p_oe8) else $error("short word not eight link cycles");
  property p_oe9;
    @(posedge serial_timing_clk) disable iff (rst)
      $rose(serial_line_oe) && tx_sh[uss_pkg::TXC_NINTH_ENABLE] |-> s_word8 ##1 serial_line_oe ##1 !serial_line_oe;
  endproperty
  a_oe9: assert property (p_oe9) else $error("long word not nine link cycles");
endmodule

bind uss_core uss_core_sva #(.RX_DEPTH(RX_DEPTH)) u_sva (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_timing_clk(serial_timing_clk), .serial_line_oe(serial_line_oe), .wake_req(wake_req), .irq_req(irq_req));

/* File: verif/uss_master_model.sv */
/*
  master at the far end of the link: makes the shift clock in bursts,
  drives the data pin or collects the slave's bits.
  assumes the slave updates and samples on rising edges.
*/
module uss_master_model (
  output logic serial_timing_clk,
  output logic serial_line_in,
  input wire logic serial_line_out,
  input wire logic serial_line_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv;
  logic bit_val;
  logic [31:0] cap;
  int ncap;

  // a released line shows the opposite of its last bit
  assign serial_line_in = serial_line_oe ? serial_line_out : (drv ? bit_val : ~bit_val);

  initial begin
    serial_timing_clk = 1'b0;
    drv = 1'b0;
    bit_val = 1'b0;
    cap = '0;
    ncap = 0;
  end

  // slave bits are steady at the falling edge
  always @(negedge serial_timing_clk) begin
    if (serial_line_oe && ncap < 32) begin
      cap[ncap] = serial_line_out;
      ncap = ncap + 1;
    end
  end

  // clock stands low outside bursts; data changes while it is low
  task automatic burst(input int n, input logic [8:0] d, input logic drive);
    for (int i = 0; i < n; i++) begin
      drv = drive;
      bit_val = (i < 9) ? d[i] : 1'b0;
      #7.5 serial_timing_clk = 1'b1;
      #7.5 serial_timing_clk = 1'b0;
    end
    drv = 1'b0;
  endtask
endmodule

/* File: verif/usart_sync_slave_tb.sv */
/*
  testbench for the synchronous slave serial unit: register tasks,
  one task per scenario, closing report.
  assumes the master model and the bound checker.
*/
module usart_sync_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk;
  logic rst;
  logic [uss_pkg::ADDR_W-1:0] reg_addr;
  logic [uss_pkg::DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [uss_pkg::DATA_W-1:0] reg_rdata;
  logic serial_timing_clk;
  logic serial_line_in;
  logic serial_line_out;
  logic serial_line_oe;
  logic wake_req;
  logic irq_req;
  int n_fail;
  int check_count;
  int cycles;

  uss_core dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_timing_clk(serial_timing_clk),
    .serial_line_in(serial_line_in), .serial_line_out(serial_line_out), .serial_line_oe(serial_line_oe),
    .wake_req(wake_req), .irq_req(irq_req));
  uss_master_model m (.serial_timing_clk(serial_timing_clk), .serial_line_in(serial_line_in),
    .serial_line_out(serial_line_out), .serial_line_oe(serial_line_oe));

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      n_fail = n_fail + 1;
      results();
    end
  end

  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(d & mask, exp);
    @(posedge ref_clk);
  endtask

  // run the link, then let the crossing settle
  task automatic link(input int n, input logic [8:0] d, input logic drive);
    m.burst(n, d, drive);
    repeat (10) @(posedge ref_clk);
  endtask

  // port off resets the link; the new setting then needs sync edges to cross
  task automatic rx_on(input logic [7:0] cfg);
    wr(uss_pkg::ADDR_RX_CTRL, 8'h00);
    wr(uss_pkg::ADDR_RX_CTRL, cfg);
    link(uss_pkg::SYNC_STAGES + 1, 9'h000, 1'b0);
  endtask

  task automatic t_idle_modes();
    wr(uss_pkg::ADDR_TX_CTRL, 8'h19);
    m.ncap = 0;
    wr(uss_pkg::ADDR_TX_DATA, 8'h55);
    link(20, 9'h000, 1'b0);
    chk(m.ncap, 0);
    wr(uss_pkg::ADDR_RX_CTRL, 8'h03);
    wr(uss_pkg::ADDR_TX_CTRL, 8'h09);
    link(20, 9'h000, 1'b0);
    chk(m.ncap, 0);
    rdchk(uss_pkg::ADDR_TX_CTRL, 8'h20, 8'h00);
  endtask

  task automatic t_reset();
    rdchk(uss_pkg::ADDR_RX_CTRL, 8'hFF, uss_pkg::RX_CTRL_RST);
    rdchk(uss_pkg::ADDR_IRQ_EN, 8'hFF, uss_pkg::IRQ_EN_RST);
    rdchk(uss_pkg::ADDR_TX_CTRL, 8'h1F, uss_pkg::TX_CTRL_RST & 8'h1F);
    wr(3'h6, 8'hFF);
    rdchk(3'h6, 8'hFF, 8'h00);
  endtask

  task automatic t_tx();
    wr(uss_pkg::ADDR_RX_CTRL, 8'h01);
    wr(uss_pkg::ADDR_TX_CTRL, 8'h09);
    wr(uss_pkg::ADDR_IRQ_EN, 8'h03);
    m.ncap = 0;
    wr(uss_pkg::ADDR_TX_DATA, 8'hA5);
    wr(uss_pkg::ADDR_TX_DATA, 8'h3C);
    rdchk(uss_pkg::ADDR_TX_CTRL, 8'h20, 8'h00);
    chk(wake_req, 1'b0);
    link(40, 9'h000, 1'b0);
    chk(m.ncap, 16);
    chk(m.cap[15:0], 16'h3CA5);
    rdchk(uss_pkg::ADDR_TX_CTRL, 8'h20, 8'h20);
    chk({wake_req, irq_req}, 2'h2);
    wr(uss_pkg::ADDR_IRQ_EN, 8'h0B);
    chk(irq_req, 1'b1);
    wr(uss_pkg::ADDR_IRQ_EN, 8'h02);
    chk(wake_req, 1'b0);
    wr(uss_pkg::ADDR_TX_CTRL, 8'h0F);
    m.ncap = 0;
    wr(uss_pkg::ADDR_TX_DATA, 8'hD2);
    link(20, 9'h000, 1'b0);
    chk(m.ncap, 9);
    chk(m.cap[8:0], 9'h1D2);
  endtask

  task automatic t_rx();
    wr(uss_pkg::ADDR_TX_CTRL, 8'h08);
    wr(uss_pkg::ADDR_IRQ_EN, 8'h0C);
    rx_on(8'h07);
    link(8, 9'h05A, 1'b1);
    rdchk(uss_pkg::ADDR_RX_CTRL, 8'h60, 8'h40);
    chk({wake_req, irq_req}, 2'h3);
    link(8, 9'h0C3, 1'b1);
    link(8, 9'h077, 1'b1);
    rdchk(uss_pkg::ADDR_RX_CTRL, 8'h60, 8'h60);
    link(8, 9'h0EE, 1'b1);
    rdchk(uss_pkg::ADDR_RX_DATA, 8'hFF, 8'h5A);
    rdchk(uss_pkg::ADDR_RX_DATA, 8'hFF, 8'hC3);
    rdchk(uss_pkg::ADDR_RX_DATA, 8'hFF, 8'h00);
    rdchk(uss_pkg::ADDR_RX_CTRL, 8'h60, 8'h20);
    wr(uss_pkg::ADDR_RX_CTRL, 8'h01);
    rdchk(uss_pkg::ADDR_RX_CTRL, 8'h60, 8'h00);
    rx_on(8'h0D);
    link(9, 9'h12B, 1'b1);
    rdchk(uss_pkg::ADDR_RX_CTRL, 8'h50, 8'h50);
    rdchk(uss_pkg::ADDR_RX_DATA, 8'hFF, 8'h2B);
    link(9, 9'h034, 1'b1);
    wr(uss_pkg::ADDR_RX_CTRL, 8'h0C);
    rdchk(uss_pkg::ADDR_RX_DATA, 8'hFF, 8'h00);
    wr(uss_pkg::ADDR_RX_CTRL, 8'h0D);
    rdchk(uss_pkg::ADDR_RX_CTRL, 8'h70, 8'h00);
  endtask

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_fail = 0;
    check_count = 0;
    cycles = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_tx();
    t_idle_modes();
    t_rx();
    results();
  end
endmodule
